// File: hw/msp_device.sv
// Strobed register access was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module msp_device import msp_pkg::*; #(
  parameter int RST_PULSE_CYC = MSP_RST_PULSE_CYC
) (
  input  wire logic clock,            // System clock
  input  wire logic sys_rst,          // Sync reset
  msp_link_if.dev   link,             // Serial link
  input  wire logic strap_gnd,        // Strap tied low
  input  wire logic strap_vcc,        // Strap tied high
  input  wire logic rst_pin_i,        // Reset pin level
  output logic      rst_pin_o,        // Reset pin drive value
  output logic      rst_pin_oe,       // Reset pin drive enable
  input  wire logic intrusion_i,      // Chassis intrusion input
  input  wire logic [7:0] stat1_i,    // Status register one source
  input  wire logic [7:0] stat2_i,    // Status register two source
  output logic [7:0] ptr_o,           // Register address pointer
  output logic [7:0] config_o,        // Configuration register
  output logic      intrusion_o       // Intrusion latch
);
  // ****************************************
  // Input synchronisers
  // ****************************************
  logic scl_s, sda_s, rstn_s, intr_s;
  msp_sync u_scl (.clock(clock), .sys_rst(sys_rst), .rst_val(1'b1), .d_in(link.scl), .q_out(scl_s));
  msp_sync u_sda (.clock(clock), .sys_rst(sys_rst), .rst_val(1'b1), .d_in(link.sda), .q_out(sda_s));
  msp_sync u_rst (.clock(clock), .sys_rst(sys_rst), .rst_val(1'b1), .d_in(rst_pin_i), .q_out(rstn_s));
  msp_sync u_int (.clock(clock), .sys_rst(sys_rst), .rst_val(1'b1), .d_in(intrusion_i), .q_out(intr_s));

  logic scl_d_reg, sda_d_reg;
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      scl_d_reg <= 1'b1;
      sda_d_reg <= 1'b1;
    end else begin
      scl_d_reg <= scl_s;
      sda_d_reg <= sda_s;
    end
  end
  wire scl_rise = scl_s & ~scl_d_reg;
  wire scl_fall = ~scl_s & scl_d_reg;
  wire start_det = scl_s & scl_d_reg & sda_d_reg & ~sda_s;
  wire stop_det  = scl_s & scl_d_reg & ~sda_d_reg & sda_s;

  // ****************************************
  // Strap capture
  // ****************************************
  logic       strap_done_reg;
  logic [1:0] strap_reg;
  // Strap pins are static; sampled once on the first clock after reset
  wire [1:0] strap_code = strap_gnd ? MSP_STRAP_GND : (strap_vcc ? MSP_STRAP_VCC : MSP_STRAP_OPEN);
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      strap_done_reg <= 1'b0;
      strap_reg      <= MSP_STRAP_OPEN;
    end else if (!strap_done_reg) begin
      strap_done_reg <= 1'b1;
      strap_reg      <= strap_code;
    end
  end
  wire [6:0] own_addr = {MSP_ADDR_HI, strap_reg};

  // ****************************************
  // Protocol engine
  // ****************************************
  msp_dev_state_t state_reg;
  logic [7:0] shift_reg;
  logic [3:0] bit_reg;
  logic       second_reg;
  logic       sda_oe_reg;
  logic       reg_wr;
  logic [7:0] reg_wdata;
  logic [7:0] rdata;
  logic       regs_rst;
  logic       third_reg;

  wire [7:0] shifted = {shift_reg[6:0], sda_s};

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      state_reg  <= MSP_D_IDLE;
      shift_reg  <= 8'h00;
      bit_reg    <= 4'h0;
      second_reg <= 1'b0;
      third_reg  <= 1'b0;
      sda_oe_reg <= 1'b0;
    end else if (start_det) begin
      state_reg  <= MSP_D_ADDR;
      bit_reg    <= 4'h0;
      sda_oe_reg <= 1'b0;
      second_reg <= 1'b0;
      third_reg  <= 1'b0;
    end else if (stop_det) begin
      state_reg  <= MSP_D_IDLE;
      sda_oe_reg <= 1'b0;
    end else begin
      unique case (state_reg)
        MSP_D_IDLE, MSP_D_WAIT: begin
        end
        MSP_D_ADDR: begin
          if (scl_rise) begin
            shift_reg <= shifted;
            bit_reg   <= bit_reg + 4'h1;
          end
          if (scl_fall && bit_reg == 4'h8) begin
            if (shift_reg[7:1] == own_addr) begin
              sda_oe_reg <= 1'b1;
              state_reg  <= MSP_D_AACK;
            end else begin
              state_reg  <= MSP_D_WAIT;
            end
          end
        end
        MSP_D_AACK: begin
          if (scl_fall) begin
            bit_reg <= 4'h0;
            if (shift_reg[0]) begin
              shift_reg  <= rdata;
              sda_oe_reg <= ~rdata[7];
              state_reg  <= MSP_D_RBYTE;
            end else begin
              sda_oe_reg <= 1'b0;
              state_reg  <= MSP_D_WBYTE;
            end
          end
        end
        MSP_D_WBYTE: begin
          if (scl_rise) begin
            shift_reg <= shifted;
            bit_reg   <= bit_reg + 4'h1;
          end
          if (scl_fall && bit_reg == 4'h8) begin
            // Pointer and data bytes are acked; a third byte is refused
            if (third_reg) begin
              state_reg <= MSP_D_WAIT;
            end else begin
              sda_oe_reg <= 1'b1;
              state_reg  <= MSP_D_WACK;
            end
          end
        end
        MSP_D_WACK: begin
          if (scl_fall) begin
            sda_oe_reg <= 1'b0;
            bit_reg    <= 4'h0;
            second_reg <= 1'b1;
            third_reg  <= second_reg;
            state_reg  <= MSP_D_WBYTE;
          end
        end
        MSP_D_RBYTE: begin
          if (scl_fall) begin
            bit_reg <= bit_reg + 4'h1;
            if (bit_reg == 4'h7) begin
              sda_oe_reg <= 1'b0;
              state_reg  <= MSP_D_RACK;
            end else begin
              shift_reg  <= {shift_reg[6:0], 1'b0};
              sda_oe_reg <= ~shift_reg[6];
            end
          end
        end
        MSP_D_RACK: begin
          if (scl_fall) begin
            state_reg <= MSP_D_WAIT;
          end
        end
        default: state_reg <= MSP_D_IDLE;
      endcase
    end
  end
  assign link.sda_dev_o  = 1'b0;
  assign link.sda_dev_oe = sda_oe_reg;

  // Byte completes at the eighth-clock fall of a write byte
  wire wbyte_end = (state_reg == MSP_D_WBYTE) && scl_fall && (bit_reg == 4'h8) && !start_det && !stop_det;
  wire ptr_load  = wbyte_end && !second_reg;
  assign reg_wr    = wbyte_end && second_reg && !third_reg;
  assign reg_wdata = shift_reg;

  // ****************************************
  // Internal registers
  // ****************************************
  logic [7:0]  ptr_reg, config_reg;
  logic        intr_reg;
  logic        pulse_reg;
  logic [31:0] pulse_cnt_reg;
  logic [1:0]  pulse_tail_reg;
  // Pulse drives the pin itself, so it must not reset its own registers;
  // the tail covers the synchroniser lag once the pin is let go
  wire pulse_mask = pulse_reg | pulse_tail_reg[0] | pulse_tail_reg[1];
  assign regs_rst = sys_rst | (~rstn_s & ~pulse_mask);
  wire clr_write = reg_wr && (ptr_reg == MSP_REG_INTR_CLR);

  always_ff @(posedge clock) begin
    if (regs_rst) begin
      ptr_reg    <= MSP_PTR_RESET;
      config_reg <= MSP_CFG_RESET;
      intr_reg   <= 1'b0;
    end else begin
      if (ptr_load) ptr_reg <= shift_reg;
      if (reg_wr && ptr_reg == MSP_REG_CONFIG) config_reg <= reg_wdata;
      else config_reg[MSP_CFG_RSTREQ_BIT] <= 1'b0;
      if (!intr_s) intr_reg <= 1'b1;
      else if (clr_write) intr_reg <= 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      pulse_reg     <= 1'b0;
      pulse_cnt_reg <= 32'h0000_0000;
    end else if (config_reg[MSP_CFG_RSTREQ_BIT] && !pulse_reg) begin
      pulse_reg     <= 1'b1;
      pulse_cnt_reg <= 32'(RST_PULSE_CYC - 1);
    end else if (pulse_reg) begin
      if (pulse_cnt_reg == 32'h0000_0000) pulse_reg <= 1'b0;
      else pulse_cnt_reg <= pulse_cnt_reg - 32'h0000_0001;
    end
  end
  always_ff @(posedge clock) begin
    if (sys_rst) pulse_tail_reg <= 2'h0;
    else pulse_tail_reg <= {pulse_tail_reg[0], pulse_reg};
  end
  assign rst_pin_o  = 1'b0;
  assign rst_pin_oe = pulse_reg;

  // Read mux; mirrors return the primary contents
  assign rdata = (ptr_reg == MSP_REG_STAT1 || ptr_reg == MSP_REG_STAT1_MIR) ? stat1_i :
                 (ptr_reg == MSP_REG_STAT2 || ptr_reg == MSP_REG_STAT2_MIR) ? stat2_i :
                 (ptr_reg == MSP_REG_CONFIG) ? config_reg :
                 (ptr_reg == MSP_REG_INTR_CLR) ? {7'h00, intr_reg} : 8'h00;

  assign ptr_o       = ptr_reg;
  assign config_o    = config_reg;
  assign intrusion_o = intr_reg;
endmodule
`default_nettype wire

// File: hw/msp_host.sv
`timescale 1ns/1ps
`default_nettype none
module msp_host import msp_pkg::*; #(
  parameter int HALF_CYC = MSP_SCL_HALF_CYC
) (
  input  wire logic       clock,    // System clock
  input  wire logic       sys_rst,  // Sync reset
  msp_link_if.host        link,     // Serial link
  input  wire logic [2:0] addr,     // Register address
  input  wire logic [7:0] wdata,    // Write data
  input  wire logic       wr,       // Write strobe
  input  wire logic       rd,       // Read strobe
  output logic [7:0]      rdata     // Read data, next cycle
);
  // ****************************************
  // Command registers
  // ****************************************
  logic [6:0] dev_addr_reg;
  logic [7:0] wdata_reg, rx_reg;
  logic [1:0] nbytes_reg;   // 0 read, 1 pointer only, 2 pointer+data
  logic [7:0] ptr_reg;
  logic       busy_reg, nack_reg;
  msp_host_state_t state_reg;
  wire go = wr && addr == MSP_HREG_CTRL && !busy_reg;

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      dev_addr_reg <= {MSP_ADDR_HI, MSP_STRAP_OPEN};
      wdata_reg    <= 8'h00;
      ptr_reg      <= 8'h00;
      nbytes_reg   <= 2'h0;
    end else if (wr) begin
      if (addr == MSP_HREG_ADDR)  dev_addr_reg <= wdata[6:0];
      if (addr == MSP_HREG_WDATA) wdata_reg    <= wdata;
      if (addr == MSP_HREG_PTR)   ptr_reg      <= wdata;
      if (go)                     nbytes_reg   <= wdata[1:0];
    end
  end
  always_ff @(posedge clock) begin
    if (sys_rst) rdata <= 8'h00;
    else if (rd) begin
      unique case (addr)
        MSP_HREG_ADDR:   rdata <= {1'b0, dev_addr_reg};
        MSP_HREG_STATUS: rdata <= {6'h00, nack_reg, busy_reg};
        MSP_HREG_RDATA:  rdata <= rx_reg;
        default:         rdata <= 8'h00;
      endcase
    end
  end

  // ****************************************
  // Bit engine
  // ****************************************
  logic [7:0]  tick_reg;
  logic [1:0]  phase_reg;   // 0 low-setup, 1 rise, 2 high, 3 fall
  logic [3:0]  bit_reg;
  logic [1:0]  byte_reg;
  logic [7:0]  tx_reg;
  logic        scl_reg, sda_reg;
  wire tick = (tick_reg == 8'(HALF_CYC - 1));
  wire is_read = (nbytes_reg == 2'h0);
  wire last_byte = is_read ? (byte_reg == 2'h1) : (byte_reg == nbytes_reg);
  wire sda_in;
  msp_sync u_sda (.clock(clock), .sys_rst(sys_rst), .rst_val(1'b1), .d_in(link.sda), .q_out(sda_in));

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      state_reg <= MSP_H_IDLE;
      tick_reg  <= 8'h00;
      phase_reg <= 2'h0;
      bit_reg   <= 4'h0;
      byte_reg  <= 2'h0;
      tx_reg    <= 8'h00;
      scl_reg   <= 1'b1;
      sda_reg   <= 1'b1;
      busy_reg  <= 1'b0;
      nack_reg  <= 1'b0;
      rx_reg    <= 8'h00;
    end else begin
      tick_reg <= (tick || state_reg == MSP_H_IDLE) ? 8'h00 : tick_reg + 8'h01;
      unique case (state_reg)
        MSP_H_IDLE: if (go) begin
          busy_reg  <= 1'b1;
          nack_reg  <= 1'b0;
          sda_reg   <= 1'b0;
          tx_reg    <= {dev_addr_reg, wdata[1:0] == 2'h0};
          byte_reg  <= 2'h0;
          state_reg <= MSP_H_START;
        end
        MSP_H_START: if (tick) begin
          scl_reg   <= 1'b0;
          bit_reg   <= 4'h0;
          phase_reg <= 2'h0;
          state_reg <= MSP_H_BIT;
        end
        MSP_H_BIT: if (tick) begin
          phase_reg <= phase_reg + 2'h1;
          unique case (phase_reg)
            2'h0: begin
              if (bit_reg < 4'h8) sda_reg <= (byte_reg != 2'h0 && is_read) ? 1'b1 : tx_reg[7];
              else sda_reg <= !(byte_reg != 2'h0 && is_read) ? 1'b1 : 1'b1;
            end
            2'h1: scl_reg <= 1'b1;
            2'h2: begin
              if (bit_reg < 4'h8) begin
                tx_reg <= {tx_reg[6:0], 1'b0};
                rx_reg <= {rx_reg[6:0], sda_in};
              end else if (!(byte_reg != 2'h0 && is_read) && sda_in) nack_reg <= 1'b1;
            end
            2'h3: begin
              scl_reg <= 1'b0;
              if (bit_reg == 4'h8) begin
                bit_reg  <= 4'h0;
                byte_reg <= byte_reg + 2'h1;
                tx_reg   <= (byte_reg == 2'h0) ? ptr_reg : wdata_reg;
                if (last_byte || nack_reg) state_reg <= MSP_H_STOP;
              end else bit_reg <= bit_reg + 4'h1;
            end
            default: ;
          endcase
        end
        MSP_H_STOP: if (tick) begin
          phase_reg <= phase_reg + 2'h1;
          unique case (phase_reg)
            2'h0: sda_reg <= 1'b0;
            2'h1: scl_reg <= 1'b1;
            2'h2: sda_reg <= 1'b1;
            2'h3: begin
              busy_reg  <= 1'b0;
              state_reg <= MSP_H_IDLE;
            end
            default: ;
          endcase
        end
        default: state_reg <= MSP_H_IDLE;
      endcase
    end
  end
  assign link.scl_o       = 1'b0;
  assign link.scl_oe      = ~scl_reg;
  assign link.sda_host_o  = 1'b0;
  assign link.sda_host_oe = ~sda_reg;
endmodule
`default_nettype wire

// File: hw/msp_link_if.sv
`timescale 1ns/1ps
`default_nettype none
interface msp_link_if;
  logic scl_o;
  logic scl_oe;
  logic sda_host_o;
  logic sda_host_oe;
  logic sda_dev_o;
  logic sda_dev_oe;
  wire  scl = ~(scl_oe & ~scl_o);
  wire  sda = ~((sda_host_oe & ~sda_host_o) | (sda_dev_oe & ~sda_dev_o));
  modport dev  (input scl, input sda, output sda_dev_o, output sda_dev_oe);
  modport host (input scl, input sda, output scl_o, output scl_oe, output sda_host_o, output sda_host_oe);
endinterface
`default_nettype wire

// File: hw/msp_pkg.sv
// Operation
// - Address is 01011 plus two strap bits
// - Strap ground 10, supply 01, open 00
// - Strap captured once after reset release
// - Start, then seven address bits, direction
// - Matching address acknowledged; others idle till start
// - Direction zero writes, one reads
// - Nine clocks per byte, device acks writes
// - SDA rise with SCL high is stop
// - Master ends write with stop
// - Read ends with nack then stop
// - Direction holds until operation ends
// - Writes carry one or two bytes; reads one
// - First write byte loads address pointer
// - Second write byte stored at pointer
// - Pointer kept; read returns selected register
// - Master writes pointer before reading elsewhere
// - Low reset pin restores register defaults
// - Software reset request drives 45 ms pulse
// - Status registers mirrored at 4Ch, 4Dh
// - Intrusion latch cleared by clear-register write
package msp_pkg;
  localparam logic [4:0] MSP_ADDR_HI        = 5'h0B;
  localparam logic [1:0] MSP_STRAP_GND      = 2'h2;
  localparam logic [1:0] MSP_STRAP_VCC      = 2'h1;
  localparam logic [1:0] MSP_STRAP_OPEN     = 2'h0;
  localparam logic [7:0] MSP_REG_CONFIG     = 8'h40;
  localparam logic [7:0] MSP_REG_STAT1      = 8'h41;
  localparam logic [7:0] MSP_REG_STAT2      = 8'h42;
  localparam logic [7:0] MSP_REG_STAT1_MIR  = 8'h4C;
  localparam logic [7:0] MSP_REG_STAT2_MIR  = 8'h4D;
  localparam logic [7:0] MSP_REG_INTR_CLR   = 8'h46;
  localparam logic [7:0] MSP_CFG_RESET      = 8'h00;
  localparam logic [7:0] MSP_PTR_RESET      = 8'h00;
  localparam int         MSP_CFG_RSTREQ_BIT = 4;
  localparam int         MSP_CFG_INTR_BIT   = 0;
  localparam int         MSP_CLK_MHZ        = 100;
  localparam int         MSP_RST_PULSE_MS   = 45;
  localparam int         MSP_RST_PULSE_CYC  = MSP_RST_PULSE_MS * 1000 * 1000 / (1000 / MSP_CLK_MHZ);
  localparam int         MSP_SCL_HALF_CYC   = 63;
  localparam logic [2:0] MSP_HREG_CTRL      = 3'h0;
  localparam logic [2:0] MSP_HREG_ADDR      = 3'h1;
  localparam logic [2:0] MSP_HREG_WDATA     = 3'h2;
  localparam logic [2:0] MSP_HREG_STATUS    = 3'h3;
  localparam logic [2:0] MSP_HREG_RDATA     = 3'h4;
  localparam logic [2:0] MSP_HREG_PTR       = 3'h5;
  typedef enum logic [3:0] {
    MSP_D_IDLE = 4'h0, MSP_D_ADDR = 4'h1, MSP_D_AACK = 4'h3, MSP_D_WBYTE = 4'h2,
    MSP_D_WACK = 4'h6, MSP_D_RBYTE = 4'h7, MSP_D_RACK = 4'h5, MSP_D_WAIT = 4'h4
  } msp_dev_state_t;
  typedef enum logic [2:0] {
    MSP_H_IDLE = 3'h0, MSP_H_START = 3'h1, MSP_H_BIT = 3'h3, MSP_H_STOP = 3'h2
  } msp_host_state_t;
endpackage

// File: hw/msp_sync.sv
`timescale 1ns/1ps
`default_nettype none
module msp_sync import msp_pkg::*; (
  input  wire logic clock,    // System clock
  input  wire logic sys_rst,  // Sync reset
  input  wire logic rst_val,  // Value held in reset
  input  wire logic d_in,     // Async input
  output logic      q_out     // Synchronised level
);
  logic meta_reg;
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      meta_reg <= rst_val;
      q_out    <= rst_val;
    end else begin
      meta_reg <= d_in;
      q_out    <= meta_reg;
    end
  end
endmodule
`default_nettype wire

// File: test/msp_link_chk.sv
`timescale 1ns/1ps
`default_nettype none
// ****************
// Link checker
// ****************
module msp_link_chk (
  input wire logic clock,        // System clock
  input wire logic sys_rst,      // Sync reset
  input wire logic scl,          // Link clock wire
  input wire logic sda,          // Link data wire
  input wire logic scl_oe,       // Host clock pull
  input wire logic sda_host_oe,  // Host data pull
  input wire logic sda_dev_oe    // Device data pull
);
  logic       scl_q;
  logic       sda_q;
  logic       dir_q;
  logic [5:0] cnt_q;
  wire        start_w = scl & scl_q & sda_q & ~sda;
  wire        stop_w  = scl & scl_q & ~sda_q & sda;
  wire        rise_w  = scl & ~scl_q;
  always_ff @(posedge clock) begin
    scl_q <= scl;
    sda_q <= sda;
  end
  // Clock rises since start; saturates so a stuck bus cannot wrap into a legal slot
  always_ff @(posedge clock) begin
    if (sys_rst || start_w) begin
      cnt_q <= 6'h00;
    end else if (rise_w && cnt_q != 6'h3F) begin
      cnt_q <= cnt_q + 6'h01;
    end
  end
  always_ff @(posedge clock) begin
    if (rise_w && cnt_q == 6'h07) begin
      dir_q <= sda;
    end
  end
  default clocking @(posedge clock); endclocking
  default disable iff (sys_rst);
  property p_rst_idle;
    $fell(sys_rst) |-> !scl_oe && !sda_host_oe && !sda_dev_oe;
  endproperty
  a_rst_idle: assert property (p_rst_idle) else $error("link driven after reset");
  property p_dev_low_only;
    $changed(sda_dev_oe) |-> !scl && !$past(scl);
  endproperty
  a_dev_low_only: assert property (p_dev_low_only) else $error("device data moved with clock high");
  property p_no_dev_frame;
    scl && $past(scl) && $changed(sda) |-> !sda_dev_oe && !$past(sda_dev_oe);
  endproperty
  a_no_dev_frame: assert property (p_no_dev_frame) else $error("device made start or stop");
  property p_addr_quiet;
    start_w |=> !sda_dev_oe [*8];
  endproperty
  a_addr_quiet: assert property (p_addr_quiet) else $error("device drove during address");
  property p_stop_release;
    stop_w |=> !sda_dev_oe [*8];
  endproperty
  a_stop_release: assert property (p_stop_release) else $error("device drove after stop");
  property p_dev_slots;
    sda_dev_oe |-> cnt_q inside {[6'd8:6'd18], [6'd26:6'd27]};
  endproperty
  a_dev_slots: assert property (p_dev_slots) else $error("device drove outside its slots");
  property p_read_nack;
    rise_w && dir_q && cnt_q == 6'd17 |-> sda && !sda_host_oe;
  endproperty
  a_read_nack: assert property (p_read_nack) else $error("read not ended by nack");
  property p_start_clocks;
    start_w |-> ##[1:200] !scl;
  endproperty
  a_start_clocks: assert property (p_start_clocks) else $error("no clock after start");
  property p_stop_idle;
    stop_w |=> !scl_oe [*8];
  endproperty
  a_stop_idle: assert property (p_stop_idle) else $error("clock pulled after stop");
endmodule
`default_nettype wire

// File: test/msp_test.sv
`timescale 1ns/1ps
`default_nettype none
module monitor_serial_slave_port_test import msp_pkg::*;;
  localparam int PULSE = 200;
  logic       clock       = 1'b0;
  logic       sys_rst     = 1'b1;
  logic [2:0] addr        = 3'h0;
  logic [7:0] wdata       = 8'h00;
  logic       wr          = 1'b0;
  logic       rd          = 1'b0;
  logic       strap_gnd   = 1'b0;
  logic       strap_vcc   = 1'b0;
  logic       tb_rst_n    = 1'b1;
  logic       intrusion_i = 1'b1;
  logic [7:0] stat1_i     = 8'h96;
  logic [7:0] stat2_i     = 8'h3C;
  logic [7:0] rdata;
  logic [7:0] ptr_o;
  logic [7:0] config_o;
  logic       intrusion_o;
  logic       rst_pin_o;
  logic       rst_pin_oe;
  logic [7:0] pulse_n     = 8'h00;
  int         err_count   = 0;
  int         n_checks    = 0;
  int         cyc         = 0;
  // Pin has a pull-up; our own drive and the outside world both pull it low
  wire        rst_pin_i   = tb_rst_n & ~(rst_pin_oe & ~rst_pin_o);
  msp_link_if msp_link_if_i ();
  msp_device #(.RST_PULSE_CYC(PULSE)) msp_device_i (
    .clock(clock), .sys_rst(sys_rst), .link(msp_link_if_i), .strap_gnd(strap_gnd), .strap_vcc(strap_vcc),
    .rst_pin_i(rst_pin_i), .rst_pin_o(rst_pin_o), .rst_pin_oe(rst_pin_oe), .intrusion_i(intrusion_i),
    .stat1_i(stat1_i), .stat2_i(stat2_i), .ptr_o(ptr_o), .config_o(config_o), .intrusion_o(intrusion_o));
  // Shortest legal phase keeps the run brief
  msp_host #(.HALF_CYC(6)) msp_host_i (
    .clock(clock), .sys_rst(sys_rst), .link(msp_link_if_i), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata));
  msp_link_chk msp_link_chk_i (
    .clock(clock), .sys_rst(sys_rst), .scl(msp_link_if_i.scl), .sda(msp_link_if_i.sda),
    .scl_oe(msp_link_if_i.scl_oe), .sda_host_oe(msp_link_if_i.sda_host_oe), .sda_dev_oe(msp_link_if_i.sda_dev_oe));
  // ****************
  // Tasks
  // ****************
  task automatic finish_test;
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic bus_wr(input logic [2:0] a, input logic [7:0] d);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clock);
    wr <= 1'b0;
    @(posedge clock);
  endtask
  task automatic bus_rd(input logic [2:0] a, output logic [7:0] d);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clock);
    rd <= 1'b0;
    #1;
    d = rdata;
    @(posedge clock);
  endtask
  // One whole transfer; returns the host status once idle
  task automatic xfer(input logic [1:0] op, input logic [6:0] sa, input logic [7:0] p, input logic [7:0] d,
                      output logic [7:0] st);
    bus_wr(MSP_HREG_ADDR, {1'b0, sa});
    bus_wr(MSP_HREG_PTR, p);
    bus_wr(MSP_HREG_WDATA, d);
    bus_wr(MSP_HREG_CTRL, {6'h00, op});
    st = 8'h01;
    for (int n = 0; n < 4000 && st[0] !== 1'b0; n++) begin
      bus_rd(MSP_HREG_STATUS, st);
    end
  endtask
  task automatic rd_reg(input logic [6:0] sa, input logic [7:0] p, input logic [7:0] exp);
    logic [7:0] st;
    logic [7:0] v;
    xfer(2'h1, sa, p, 8'h00, st);
    xfer(2'h0, sa, 8'h00, 8'h00, st);
    bus_rd(MSP_HREG_RDATA, v);
    chk("read byte", exp, v);
    chk("ptr after read", p, ptr_o);
  endtask
  // ****************
  // Sequence
  // ****************
  initial begin
    forever #5 clock = ~clock;
  end
  always @(posedge clock) begin
    cyc <= cyc + 1;
    pulse_n <= pulse_n + {7'h00, rst_pin_oe === 1'b1};
    if (cyc == 40000) begin
      err_count++;
      finish_test();
    end
  end
  initial begin : main
    logic [7:0] st;
    logic [7:0] v;
    logic [6:0] sa;
    logic [1:0] straps [3];
    straps = '{MSP_STRAP_OPEN, MSP_STRAP_GND, MSP_STRAP_VCC};
    for (int i = 0; i < 3; i++) begin
      strap_gnd <= (i == 1);
      strap_vcc <= (i == 2);
      sys_rst <= 1'b1;
      repeat (2) @(posedge clock);
      sys_rst <= 1'b0;
      @(posedge clock);
      sa = {MSP_ADDR_HI, straps[i]};
      bus_rd(MSP_HREG_ADDR, v);
      chk("host addr reset", {1'b0, MSP_ADDR_HI, MSP_STRAP_OPEN}, v);
      xfer(2'h1, sa, 8'h41, 8'h00, st);
      chk("own addr ack", 8'h00, {6'h00, st[1:0]});
      chk("ptr write", 8'h41, ptr_o);
      xfer(2'h1, 7'h2F, 8'h4C, 8'h00, st);
      chk("foreign addr nack", 8'h02, {6'h00, st[1:0]});
      chk("ptr untouched", 8'h41, ptr_o);
    end
    strap_gnd <= 1'b1;
    strap_vcc <= 1'b0;
    xfer(2'h2, sa, MSP_REG_CONFIG, 8'hA2, st);
    chk("strap held", 8'h00, {6'h00, st[1:0]});
    chk("config write", 8'hA2, config_o);
    xfer(2'h0, sa, 8'h00, 8'h00, st);
    bus_rd(MSP_HREG_RDATA, v);
    chk("read selected", 8'hA2, v);
    chk("ptr no advance", MSP_REG_CONFIG, ptr_o);
    rd_reg(sa, MSP_REG_STAT1, stat1_i);
    rd_reg(sa, MSP_REG_STAT2, stat2_i);
    rd_reg(sa, MSP_REG_STAT1_MIR, stat1_i);
    rd_reg(sa, MSP_REG_STAT2_MIR, stat2_i);
    intrusion_i <= 1'b0;
    repeat (4) @(posedge clock);
    intrusion_i <= 1'b1;
    repeat (8) @(posedge clock);
    chk("intrusion latched", 8'h01, {7'h00, intrusion_o});
    xfer(2'h2, sa, MSP_REG_INTR_CLR, 8'h00, st);
    chk("intrusion cleared", 8'h00, {7'h00, intrusion_o});
    tb_rst_n <= 1'b0;
    repeat (6) @(posedge clock);
    tb_rst_n <= 1'b1;
    repeat (6) @(posedge clock);
    chk("config pin reset", MSP_CFG_RESET, config_o);
    chk("ptr pin reset", MSP_PTR_RESET, ptr_o);
    xfer(2'h2, sa, MSP_REG_CONFIG, 8'h10, st);
    for (int n = 0; n < 600 && rst_pin_oe !== 1'b0; n++) begin
      @(posedge clock);
    end
    @(posedge clock);
    chk("pulse released", 8'h00, {7'h00, rst_pin_oe});
    chk("pulse length", 8'hC8, pulse_n);
    chk("ptr kept over pulse", MSP_REG_CONFIG, ptr_o);
    finish_test();
  end
endmodule
`default_nettype wire
